// [hdl/sps_pkg.sv]
// setup parameter store: shared constants, field layouts and types
// assumes one 100 MHz clock; all ports synchronous to it
package sps_pkg;

    // ****************************************************************
    // error classes and defaults
    // ****************************************************************
    localparam int        NUM_ERR_CLASSES = 7;
    localparam int        MAX_LINES       = 8;
    localparam logic [6:0] TRAP_DEFAULT   = 7'h7b; // bit2 active interrupt off
    localparam logic [15:0] TIMEOUT_DEFAULT = 16'h00c8;
    localparam logic [15:0] TIMEOUT_MAX     = 16'hea60;
    localparam logic [7:0]  HALT_DEFAULT    = 8'h13;
    localparam logic [7:0]  RESUME_DEFAULT  = 8'h11;
    localparam logic [31:0] TERM_DEFAULT    = 32'h00000d0a;
    localparam logic [7:0]  LINE_LEN_DEFAULT = 8'h4f;
    localparam logic [7:0]  LINE_LEN_MIN     = 8'h0a;

    // ****************************************************************
    // parameter selectors for the write port
    // ****************************************************************
    typedef enum logic [3:0] {
        SPS_SEL_TRAP,
        SPS_SEL_LINE,
        SPS_SEL_BUS_ADDR,
        SPS_SEL_RUN_ADDR,
        SPS_SEL_TIMEOUT,
        SPS_SEL_EXERCISE,
        SPS_SEL_BEEP,
        SPS_SEL_HALT,
        SPS_SEL_RESUME,
        SPS_SEL_TERM,
        SPS_SEL_LINE_LEN
    } sps_sel_t;

    // one operator entry: selector, item index, value
    typedef struct packed {
        sps_sel_t    sel;
        logic [2:0]  idx;
        logic [31:0] value;
    } sps_entry_t;

    // the whole configuration set as exported
    typedef struct packed {
        logic [6:0]  trap_en;
        logic [7:0]  line_en;
        logic [31:0] bus_test_addr;
        logic [31:0] target_run_addr;
        logic [15:0] timeout;
        logic        error_loop_prompt_enable;
        logic        beep_enable;
        logic        aux_present;
        logic [7:0]  halt_char;
        logic [7:0]  resume_char;
        logic [31:0] line_terminator;
        logic [7:0]  max_line_length;
    } sps_cfg_t;

    // what the pod supplies
    typedef struct packed {
        logic [7:0]  line_mask;
        logic [31:0] bus_test_addr;
        logic [31:0] target_run_addr;
    } sps_pod_t;

endpackage

// [hdl/sps_event_gate.sv]
// error event gate: filters error classes and forms reports and beeps
// assumes error levels arrive synchronous to clk, one bit per class
`timescale 1ns/1ns
`default_nettype none
module sps_event_gate #(
    parameter int NCLS = 7
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [NCLS-1:0] err_level,
    input  wire logic [NCLS-1:0] enable,
    input  wire logic            exercise,
    input  wire logic            beep_en,
    output logic [NCLS-1:0]      show_ff,
    output logic [NCLS-1:0]      serial_ff,
    output logic                 loop_prompt_ff,
    output logic                 beep_ff
);
    if (NCLS < 1) begin : g_bad_ncls
        $error("sps_event_gate: NCLS must be positive");
    end

    logic [NCLS-1:0] prev_ff;
    wire  [NCLS-1:0] gated = err_level & enable;
    wire  [NCLS-1:0] rise  = gated & ~prev_ff;
    wire  [NCLS-1:0] fall  = prev_ff & ~gated;
    // exercise off still sends to serial, but never shows or prompts
    wire  [NCLS-1:0] nxt_show   = exercise ? rise : '0;
    wire             nxt_prompt = exercise & (|rise);
    wire             nxt_beep   = beep_en & (|(rise | fall));

    // one-cycle pulses per transition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff        <= '0;
            show_ff        <= '0;
            serial_ff      <= '0;
            loop_prompt_ff <= 1'b0;
            beep_ff        <= 1'b0;
        end else begin
            prev_ff        <= gated;
            show_ff        <= nxt_show;
            serial_ff      <= rise;
            loop_prompt_ff <= nxt_prompt;
            beep_ff        <= nxt_beep;
        end
    end
endmodule
`default_nettype wire

// [hdl/sps_store.sv]
// setup parameter store top: holds operator configuration and gates errors
// assumes all inputs synchronous to clk; pod values stable around reset
`timescale 1ns/1ns
`default_nettype none
module sps_store #(
    parameter int NUM_LINES = sps_pkg::MAX_LINES
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire sps_pkg::sps_pod_t   pod,
    input  wire logic                aux_detect,
    input  wire logic                immediate_mode,
    input  wire logic                wr_req,
    input  wire sps_pkg::sps_entry_t wr_entry,
    input  wire logic                export_req,
    input  wire logic                bus_test_req,
    input  wire logic                run_req,
    input  wire logic                run_addr_given,
    input  wire logic [31:0]         run_addr_in,
    input  wire logic [6:0]          err_level,
    output sps_pkg::sps_cfg_t        cfg_ff,
    output logic                     wr_ack_ff,
    output logic                     wr_reject_ff,
    output logic                     export_valid_ff,
    output sps_pkg::sps_cfg_t        export_ff,
    output logic                     bus_test_go_ff,
    output logic [31:0]              bus_test_addr_ff,
    output logic                     run_go_ff,
    output logic [31:0]              run_addr_ff,
    output logic [6:0]               err_show_ff,
    output logic [6:0]               err_serial_ff,
    output logic                     loop_prompt_ff,
    output logic                     beep_ff
);
    // a pod never declares more than eight switchable lines
    if (NUM_LINES < 1 || NUM_LINES > sps_pkg::MAX_LINES) begin : g_bad_lines
        $error("sps_store: NUM_LINES must be 1..8");
    end

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    // asynchronous assert, two-stage synchronous release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // power-on load of pod defaults and aux detection
    // ****************************************************************
    // high from the cycle after the pod defaults are caught
    logic loaded_ff;

    // pod values are straps: caught by a clocked load after release
    wire do_load = ~loaded_ff;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            loaded_ff <= 1'b0;
        end else begin
            loaded_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // entry range checks
    // ****************************************************************
    // refuses values outside each entry's range
    function automatic logic in_range(input sps_pkg::sps_sel_t s,
                                      input logic [31:0] v,
                                      input logic [7:0] mask,
                                      input logic [2:0] i);
        logic ok;
        ok = 1'b1;
        unique case (s)
            sps_pkg::SPS_SEL_TRAP: begin
                ok = (v[31:1] == 31'h0) && (int'(i) < sps_pkg::NUM_ERR_CLASSES);
            end
            sps_pkg::SPS_SEL_LINE: begin
                ok = (v[31:1] == 31'h0) && mask[i];
            end
            sps_pkg::SPS_SEL_BUS_ADDR: begin
                ok = 1'b1;
            end
            sps_pkg::SPS_SEL_RUN_ADDR: begin
                ok = 1'b1;
            end
            sps_pkg::SPS_SEL_TIMEOUT: begin
                ok = v <= {16'h0, sps_pkg::TIMEOUT_MAX};
            end
            sps_pkg::SPS_SEL_EXERCISE: begin
                ok = v[31:1] == 31'h0;
            end
            sps_pkg::SPS_SEL_BEEP: begin
                ok = v[31:1] == 31'h0;
            end
            sps_pkg::SPS_SEL_HALT: begin
                ok = v[31:8] == 24'h0;
            end
            sps_pkg::SPS_SEL_RESUME: begin
                ok = v[31:8] == 24'h0;
            end
            sps_pkg::SPS_SEL_TERM: begin
                ok = 1'b1;
            end
            sps_pkg::SPS_SEL_LINE_LEN: begin
                ok = (v[31:8] == 24'h0) && (v[7:0] >= sps_pkg::LINE_LEN_MIN);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // auxiliary serial entries need the fitted interface
    function automatic logic is_aux(input sps_pkg::sps_sel_t s);
        return (s == sps_pkg::SPS_SEL_HALT) || (s == sps_pkg::SPS_SEL_RESUME) ||
               (s == sps_pkg::SPS_SEL_TERM) || (s == sps_pkg::SPS_SEL_LINE_LEN);
    endfunction

    // ****************************************************************
    // write decode
    // ****************************************************************
    // lines the pod declared switchable, caught at the load cycle
    logic [7:0] line_mask_ff;
    wire  [7:0] line_mask_eff = line_mask_ff;

    // a refused entry leaves the stored value alone
    wire mode_ok   = immediate_mode;
    wire aux_ok    = ~is_aux(wr_entry.sel) | cfg_ff.aux_present;
    wire range_ok  = in_range(wr_entry.sel, wr_entry.value, line_mask_eff, wr_entry.idx);
    wire accept    = wr_req & loaded_ff & mode_ok & aux_ok & range_ok;
    wire reject    = wr_req & ~accept;
    wire [6:0] trap_bit = 7'h01 << wr_entry.idx;
    wire [7:0] line_bit = 8'h01 << wr_entry.idx;

    sps_pkg::sps_cfg_t nxt_cfg;

    // next configuration from the accepted entry
    always_comb begin
        nxt_cfg = cfg_ff;
        if (accept) begin
            unique case (wr_entry.sel)
                sps_pkg::SPS_SEL_TRAP: begin
                    nxt_cfg.trap_en = wr_entry.value[0] ?
                        (cfg_ff.trap_en | trap_bit) : (cfg_ff.trap_en & ~trap_bit);
                end
                sps_pkg::SPS_SEL_LINE: begin
                    nxt_cfg.line_en = wr_entry.value[0] ?
                        (cfg_ff.line_en | line_bit) : (cfg_ff.line_en & ~line_bit);
                end
                sps_pkg::SPS_SEL_BUS_ADDR: begin
                    nxt_cfg.bus_test_addr = wr_entry.value;
                end
                sps_pkg::SPS_SEL_RUN_ADDR: begin
                    nxt_cfg.target_run_addr = wr_entry.value;
                end
                sps_pkg::SPS_SEL_TIMEOUT: begin
                    nxt_cfg.timeout = wr_entry.value[15:0];
                end
                sps_pkg::SPS_SEL_EXERCISE: begin
                    nxt_cfg.error_loop_prompt_enable = wr_entry.value[0];
                end
                sps_pkg::SPS_SEL_BEEP: begin
                    nxt_cfg.beep_enable = wr_entry.value[0];
                end
                sps_pkg::SPS_SEL_HALT: begin
                    nxt_cfg.halt_char = wr_entry.value[7:0];
                end
                sps_pkg::SPS_SEL_RESUME: begin
                    nxt_cfg.resume_char = wr_entry.value[7:0];
                end
                sps_pkg::SPS_SEL_TERM: begin
                    nxt_cfg.line_terminator = wr_entry.value;
                end
                sps_pkg::SPS_SEL_LINE_LEN: begin
                    nxt_cfg.max_line_length = wr_entry.value[7:0];
                end
                default: begin
                    nxt_cfg = cfg_ff;
                end
            endcase
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // the load cycle takes pod defaults; later cycles take operator entries
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cfg_ff.trap_en                  <= sps_pkg::TRAP_DEFAULT;
            cfg_ff.line_en                  <= '0;
            cfg_ff.bus_test_addr            <= '0;
            cfg_ff.target_run_addr          <= '0;
            cfg_ff.timeout                  <= sps_pkg::TIMEOUT_DEFAULT;
            cfg_ff.error_loop_prompt_enable <= 1'b1;
            cfg_ff.beep_enable              <= 1'b1;
            cfg_ff.aux_present              <= 1'b0;
            cfg_ff.halt_char                <= sps_pkg::HALT_DEFAULT;
            cfg_ff.resume_char              <= sps_pkg::RESUME_DEFAULT;
            cfg_ff.line_terminator          <= sps_pkg::TERM_DEFAULT;
            cfg_ff.max_line_length          <= sps_pkg::LINE_LEN_DEFAULT;
            line_mask_ff                    <= '0;
        end else if (do_load) begin
            cfg_ff                 <= cfg_ff;
            cfg_ff.bus_test_addr   <= pod.bus_test_addr;
            cfg_ff.target_run_addr <= pod.target_run_addr;
            cfg_ff.aux_present     <= aux_detect;
            line_mask_ff           <= pod.line_mask & ((8'h01 << NUM_LINES) - 8'h01);
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ****************************************************************
    // write answer, export, bus test and run launch
    // ****************************************************************
    // the run address falls back to the stored one when none is keyed
    wire [31:0] nxt_run_addr = run_addr_given ? run_addr_in : cfg_ff.target_run_addr;

    // write answer pulses, one cycle after the request
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wr_ack_ff    <= 1'b0;
            wr_reject_ff <= 1'b0;
        end else begin
            wr_ack_ff    <= accept;
            wr_reject_ff <= reject;
        end
    end

    // export snapshot holds until the next export
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            export_valid_ff <= 1'b0;
            export_ff       <= '0;
        end else begin
            export_valid_ff <= export_req & loaded_ff;
            if (export_req & loaded_ff) begin
                export_ff <= cfg_ff;
            end
        end
    end

    // bus test launch with the stored address
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            bus_test_go_ff   <= 1'b0;
            bus_test_addr_ff <= '0;
        end else begin
            bus_test_go_ff <= bus_test_req & loaded_ff;
            if (bus_test_req) begin
                bus_test_addr_ff <= cfg_ff.bus_test_addr;
            end
        end
    end

    // run launch; the address holds until the next run request
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            run_go_ff   <= 1'b0;
            run_addr_ff <= '0;
        end else begin
            run_go_ff <= run_req & loaded_ff;
            if (run_req) begin
                run_addr_ff <= nxt_run_addr;
            end
        end
    end

    // ****************************************************************
    // error report gate
    // ****************************************************************
    // reports follow the stored enables from the next cycle on
    sps_event_gate #(
        .NCLS (sps_pkg::NUM_ERR_CLASSES)
    ) u_gate (
        .clk            (clk),
        .rst_n          (rst_n_ff),
        .err_level      (err_level),
        .enable         (cfg_ff.trap_en),
        .exercise       (cfg_ff.error_loop_prompt_enable),
        .beep_en        (cfg_ff.beep_enable),
        .show_ff        (err_show_ff),
        .serial_ff      (err_serial_ff),
        .loop_prompt_ff (loop_prompt_ff),
        .beep_ff        (beep_ff)
    );

endmodule
`default_nettype wire

// [verif/sps_pod_model.sv]
// interface pod model: switchable line set and default addresses
// assumes values stay steady across reset, as a fitted pod does
`timescale 1ns/1ns
`default_nettype none
module sps_pod_model #(
    parameter logic [7:0]  MASK = 8'h35,
    parameter logic [31:0] BUS  = 32'h00001234,
    parameter logic [31:0] RUN  = 32'h00000800
) (
    output wire sps_pkg::sps_pod_t pod
);
    // steady levels; gaps in the mask leave lines the store must refuse
    assign pod = '{MASK, BUS, RUN};
endmodule
`default_nettype wire

// [verif/sps_store_assertions.sv]
// checker for the setup parameter store: answers, exports, events
// assumes binding onto sps_store; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module sps_store_chk (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                immediate_mode,
    input wire logic                wr_req,
    input wire sps_pkg::sps_entry_t wr_entry,
    input wire logic                export_req,
    input wire logic                bus_test_req,
    input wire logic                run_req,
    input wire logic                run_addr_given,
    input wire logic [31:0]         run_addr_in,
    input wire logic [6:0]          err_level,
    input wire sps_pkg::sps_cfg_t   cfg_ff,
    input wire logic                wr_ack_ff,
    input wire logic                wr_reject_ff,
    input wire logic                export_valid_ff,
    input wire sps_pkg::sps_cfg_t   export_ff,
    input wire logic                bus_test_go_ff,
    input wire logic [31:0]         bus_test_addr_ff,
    input wire logic                run_go_ff,
    input wire logic [31:0]         run_addr_ff,
    input wire logic [6:0]          err_show_ff,
    input wire logic [6:0]          err_serial_ff,
    input wire logic                beep_ff
);
    // ****
    // settle count: the store loads late, so checks wait for it
    // ****
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    wire        rdy   = (cnt_ff == 3'h7);
    wire  [6:0] gated = err_level & cfg_ff.trap_en;
    wire  [3:0] sel   = wr_entry.sel;
    assign nxt_cnt = rdy ? cnt_ff : cnt_ff + 3'h1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    mode_lock_a: assert property (rdy && wr_req && !immediate_mode |=> wr_reject_ff && $stable(cfg_ff))
        else $error("write taken outside immediate mode");
    one_answer_a: assert property (rdy && wr_req |=> wr_ack_ff ^ wr_reject_ff)
        else $error("write answer missing or doubled");
    timeout_max_a: assert property (rdy && wr_req && sel == 4'h4
        && wr_entry.value > 32'h0000ea60 |=> wr_reject_ff && $stable(cfg_ff))
        else $error("timeout above limit kept");
    len_range_a: assert property (rdy && wr_req && sel == 4'ha
        && (wr_entry.value < 32'h0000000a || wr_entry.value > 32'h000000ff) |=> wr_reject_ff)
        else $error("line length out of range kept");
    aux_absent_a: assert property (rdy && wr_req && !cfg_ff.aux_present && sel >= 4'h7 |=> wr_reject_ff)
        else $error("aux setting taken without aux");
    addr_store_a: assert property (rdy && wr_req && immediate_mode && sel == 4'h3
        |=> wr_ack_ff && cfg_ff.target_run_addr == $past(wr_entry.value))
        else $error("keyed address not stored");
    export_now_a: assert property (rdy && export_req |=> export_valid_ff && export_ff == $past(cfg_ff))
        else $error("export not current values");
    run_addr_a: assert property (rdy && run_req |=> run_go_ff && run_addr_ff ==
        ($past(run_addr_given) ? $past(run_addr_in) : $past(cfg_ff.target_run_addr)))
        else $error("run address wrong");
    bus_addr_a: assert property (rdy && bus_test_req
        |=> bus_test_go_ff && bus_test_addr_ff == $past(cfg_ff.bus_test_addr))
        else $error("bus test address wrong");
    err_gate_a: assert property (rdy |-> err_serial_ff == ($past(gated) & ~$past(gated, 2)))
        else $error("error report not gated by enable");
    err_show_a: assert property (rdy
        |-> err_show_ff == (err_serial_ff & {7{$past(cfg_ff.error_loop_prompt_enable)}}))
        else $error("shown errors disagree with exercise");
    beep_edge_a: assert property (rdy
        |-> beep_ff == ($past(cfg_ff.beep_enable) && $past(gated) != $past(gated, 2)))
        else $error("beep not on error change");
endmodule
bind sps_store sps_store_chk chk_u (
    .clk(clk), .nrst(nrst), .immediate_mode(immediate_mode), .wr_req(wr_req), .wr_entry(wr_entry),
    .export_req(export_req), .bus_test_req(bus_test_req), .run_req(run_req), .run_addr_given(run_addr_given),
    .run_addr_in(run_addr_in), .err_level(err_level), .cfg_ff(cfg_ff), .wr_ack_ff(wr_ack_ff),
    .wr_reject_ff(wr_reject_ff), .export_valid_ff(export_valid_ff), .export_ff(export_ff),
    .bus_test_go_ff(bus_test_go_ff), .bus_test_addr_ff(bus_test_addr_ff), .run_go_ff(run_go_ff),
    .run_addr_ff(run_addr_ff), .err_show_ff(err_show_ff), .err_serial_ff(err_serial_ff), .beep_ff(beep_ff)
);
`default_nettype wire

// [verif/tb_top.sv]
// bench for the setup parameter store: corner and random writes, events
// assumes the pod model holds steady levels; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0]  MASK = 8'h35;
    localparam logic [31:0] BUSA = 32'h00001234;
    localparam logic [31:0] RUNA = 32'h00000800;
    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                aux = 1'b1;
    logic                im = 1'b1;
    logic                wrq = 1'b0;
    logic                exq = 1'b0;
    logic                btq = 1'b0;
    logic                rnq = 1'b0;
    logic                rg = 1'b0;
    logic [31:0]         ra = 32'h0;
    logic [6:0]          el = 7'h0;
    logic [15:0]         rs = 16'h0057;
    sps_pkg::sps_entry_t ent = '0;
    sps_pkg::sps_pod_t   pod;
    sps_pkg::sps_cfg_t   cfg, exf, mdl;
    logic                ack, rej, exv, btg, rng, lp, bp;
    logic [31:0]         bta, rna;
    logic [6:0]          shw, ser;
    int                  failures = 0;
    int                  n_tests = 0;
    always #5 clk = ~clk;
    sps_pod_model #(.MASK(MASK), .BUS(BUSA), .RUN(RUNA)) pod_u (.pod(pod));
    sps_store dut_u (
        .clk(clk), .nrst(nrst), .pod(pod), .aux_detect(aux), .immediate_mode(im), .wr_req(wrq),
        .wr_entry(ent), .export_req(exq), .bus_test_req(btq), .run_req(rnq), .run_addr_given(rg),
        .run_addr_in(ra), .err_level(el), .cfg_ff(cfg), .wr_ack_ff(ack), .wr_reject_ff(rej),
        .export_valid_ff(exv), .export_ff(exf), .bus_test_go_ff(btg), .bus_test_addr_ff(bta),
        .run_go_ff(rng), .run_addr_ff(rna), .err_show_ff(shw), .err_serial_ff(ser),
        .loop_prompt_ff(lp), .beep_ff(bp)
    );
    // ****
    // expectation helpers
    // ****
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // selector codes follow the package enum order
    function automatic logic acc(input logic [3:0] s, input logic [2:0] i, input logic [31:0] v);
        case (s)
            4'h0: return i != 3'h7 && v < 32'h2;
            4'h1: return MASK[i] && v < 32'h2;
            4'h2, 4'h3: return 1'b1;
            4'h4: return v <= 32'h0000ea60;
            4'h5, 4'h6: return v < 32'h2;
            4'h7, 4'h8: return aux && v < 32'h100;
            4'h9: return aux;
            4'ha: return aux && v >= 32'ha && v < 32'h100;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input logic [159:0] g, input logic [159:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic upd(input logic [3:0] s, input logic [2:0] i, input logic [31:0] v);
        case (s)
            4'h0: mdl.trap_en[i] = v[0];
            4'h1: mdl.line_en[i] = v[0];
            4'h2: mdl.bus_test_addr = v;
            4'h3: mdl.target_run_addr = v;
            4'h4: mdl.timeout = v[15:0];
            4'h5: mdl.error_loop_prompt_enable = v[0];
            4'h6: mdl.beep_enable = v[0];
            4'h7: mdl.halt_char = v[7:0];
            4'h8: mdl.resume_char = v[7:0];
            4'h9: mdl.line_terminator = v;
            default: mdl.max_line_length = v[7:0];
        endcase
    endtask
    // one write; the answer stands one cycle, so it is read right after
    task automatic wr(input logic [3:0] s, input logic [2:0] i, input logic [31:0] v);
        logic a;
        @(posedge clk);
        a = im && acc(s, i, v);
        wrq <= 1'b1;
        ent <= '{sps_pkg::sps_sel_t'(s), i, v};
        @(posedge clk);
        wrq <= 1'b0;
        #1;
        chk({ack, rej}, {a, !a});
        if (a) upd(s, i, v);
        chk(cfg, mdl);
    endtask
    task automatic op(input logic g, input logic [31:0] a);
        @(posedge clk);
        exq <= 1'b1;
        btq <= 1'b1;
        rnq <= 1'b1;
        rg <= g;
        ra <= a;
        @(posedge clk);
        exq <= 1'b0;
        btq <= 1'b0;
        rnq <= 1'b0;
        #1;
        chk({exv, exf}, {1'b1, mdl});
        chk({btg, bta}, {1'b1, mdl.bus_test_addr});
        chk({rng, rna}, {1'b1, g ? a : mdl.target_run_addr});
    endtask
    // wait past the two release flops and the load cycle before use
    task automatic rst(input logic a);
        @(posedge clk);
        nrst <= 1'b0;
        aux <= a;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        mdl = '{7'h7b, 8'h00, BUSA, RUNA, 16'h00c8, 1'b1, 1'b1, a, 8'h13, 8'h11, 32'h00000d0a, 8'h4f};
        chk(cfg, mdl);
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        logic [31:0] v;
        rst(1'b1);
        el <= 7'h04;
        wr(4'h0, 3'h2, 32'h1);
        @(posedge clk);
        #1;
        chk({ser, shw, lp, bp}, {7'h04, 7'h04, 1'b1, 1'b1});
        wr(4'h5, 3'h0, 32'h0);
        el <= 7'h00;
        @(posedge clk);
        #1;
        chk({ser, shw, lp, bp}, {7'h00, 7'h00, 1'b0, 1'b1});
        el <= 7'h04;
        @(posedge clk);
        #1;
        chk({ser, shw, lp, bp}, {7'h04, 7'h00, 1'b0, 1'b1});
        wr(4'h5, 3'h0, 32'h1);
        wr(4'h4, 3'h0, 32'h0000ea60);
        wr(4'h4, 3'h0, 32'h0000ea61);
        wr(4'ha, 3'h0, 32'h00000009);
        wr(4'ha, 3'h0, 32'h000000ff);
        wr(4'h7, 3'h0, 32'h00000100);
        wr(4'h8, 3'h0, 32'h000000ff);
        wr(4'h9, 3'h0, 32'h12345678);
        wr(4'h0, 3'h7, 32'h1);
        wr(4'h1, 3'h1, 32'h1);
        wr(4'h1, 3'h0, 32'h1);
        im <= 1'b0;
        wr(4'h2, 3'h0, 32'h0000abcd);
        im <= 1'b1;
        op(1'b0, 32'h0);
        repeat (150) begin
            rs = nx(rs);
            im <= rs[2:0] != 3'h0;
            el <= rs[9:3];
            v = {rs, nx(rs)} >> rs[15:11];
            wr(rs[3:0] % 4'hb, rs[6:4], v);
            op(rs[10], {rs, nx(rs)});
        end
        rst(1'b0);
        wr(4'h9, 3'h0, 32'h1);
        wr(4'h7, 3'h0, 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
